// ===== core/adc_request_result_control.v
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_request_result_control (
    input wire mclk,
    input wire rst_b,
    input wire [4:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire [7:0] trigger_lines,
    input wire [9:0] conv_data,
    output reg [2:0] conv_channel,
    output reg conv_sample,
    output reg [1:0] service_request_lines
);

localparam ST_IDLE = 2'h0;
localparam ST_START = 2'h1;
localparam ST_SAMPLE = 2'h2;
localparam ST_CONV = 2'h3;

reg [7:0] channel_control [0:7];
reg [7:0] input_class_sample_time;
reg [7:0] arb_r;
reg [7:0] qmode_r;
reg [3:0] par_req_r;
reg [3:0] par_pend_r;
reg [7:0] par_mode_r;
reg [7:0] trig_r;
reg [9:0] lower_limit_bound;
reg [9:0] upper_limit_bound;
reg [7:0] route_ev_r;
reg [7:0] route_ch_r;
reg [5:0] q_r [0:3];
reg [3:0] qv_r;
reg [10:0] res_r [0:3];
reg [3:0] res_valid_r;
reg [3:0] res_cnt_r;
reg [7:0] ev_flag_r;
reg [7:0] ch_flag_r;
reg load_pend_r;
reg [1:0] state_r;
reg [7:0] cnt_r;
reg [7:0] div_r;
reg [2:0] cur_ch_r;
reg cur_src_r;
reg [5:0] cur_q_r;
reg [1:0] sync0_a_r;
reg [1:0] sync1_a_r;
reg [1:0] trig_prev_r;
reg [1:0] trig_seen_r;
integer i;

wire tick = (div_r == 8'h00);
wire trig0_raw = trigger_lines[trig_r[2:0]];
wire trig1_raw = trigger_lines[trig_r[6:4]];
wire trig0 = trig_r[3] ? trig0_raw : sync0_a_r[1];
wire trig1 = trig_r[7] ? trig1_raw : sync1_a_r[1];
wire trig0_edge = trig0 & ~trig_prev_r[0];
wire trig1_edge = trig1 & ~trig_prev_r[1];

function [1:0] target_of;
    input [2:0] ch;
    begin
        target_of = channel_control[ch][`F_TARGET_LSB+1:`F_TARGET_LSB];
    end
endfunction

function blocked;
    input [2:0] ch;
    begin
        blocked = arb_r[6] & res_valid_r[target_of(ch)];
    end
endfunction

function [1:0] top_bit;
    input [3:0] m;
    begin
        top_bit = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
    end
endfunction

wire [5:0] q_head = q_r[0];
wire q_trig_ok = ~q_head[3] | trig_seen_r[0];
wire seq_req = qv_r[0] & arb_r[0] & qmode_r[0] & q_trig_ok & ~blocked(q_head[2:0]);
wire [1:0] par_bit = top_bit(par_pend_r);
wire [2:0] par_ch = {1'b1, par_bit};
wire par_req = (|par_pend_r) & arb_r[1] & par_mode_r[0] & ~blocked(par_ch);
wire seq_win = seq_req & (arb_r[2] | ~par_req | ~arb_r[3]);
wire par_win = par_req & ~seq_win;
wire busy = (state_r != ST_IDLE);
wire cancel_ok = busy & ((seq_win & ~cur_src_r & 1'b0) | (seq_win & cur_src_r & arb_r[2] & ~arb_r[3] & arb_r[4])
    | (par_win & ~cur_src_r & arb_r[3] & ~arb_r[2] & arb_r[5]));
wire full = &qv_r;
wire done = (state_r == ST_CONV) & tick & (cnt_r == 8'h00);
wire [1:0] tgt = target_of(cur_ch_r);
wire [11:0] acc = {1'b0, res_r[tgt]} + {2'b00, conv_data};
wire acc_mode = arb_r[7];
wire [1:0] limit_check_control = channel_control[cur_ch_r][`F_LIMIT_LSB+1:`F_LIMIT_LSB];
wire below = conv_data < lower_limit_bound;
wire above = conv_data > upper_limit_bound;
reg lim_hit;
always @* begin
    case (limit_check_control)
        2'h0: lim_hit = 1'b0;
        2'h1: lim_hit = ~below & ~above;
        2'h2: lim_hit = below | above;
        default: lim_hit = 1'b1;
    endcase
end

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        sync0_a_r <= 2'h0;
        sync1_a_r <= 2'h0;
        trig_prev_r <= 2'h0;
    end else begin
        sync0_a_r <= {sync0_a_r[0], trig0_raw};
        sync1_a_r <= {sync1_a_r[0], trig1_raw};
        trig_prev_r <= {trig1, trig0};
    end
end

always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        for (i = 0; i < 8; i = i + 1) begin
            channel_control[i] <= `RST_CHAN_CTRL;
        end
        for (i = 0; i < 4; i = i + 1) begin
            q_r[i] <= 6'h00;
            res_r[i] <= 11'h000;
        end
        input_class_sample_time <= `RST_SAMPLE_TIME;
        arb_r <= `RST_ARB_CTRL;
        qmode_r <= 8'h00;
        par_req_r <= 4'h0;
        par_pend_r <= 4'h0;
        par_mode_r <= 8'h00;
        trig_r <= 8'h00;
        lower_limit_bound <= 10'h000;
        upper_limit_bound <= 10'h3FF;
        route_ev_r <= 8'h00;
        route_ch_r <= 8'h00;
        qv_r <= 4'h0;
        res_valid_r <= 4'h0;
        res_cnt_r <= 4'h0;
        ev_flag_r <= 8'h00;
        ch_flag_r <= 8'h00;
        load_pend_r <= 1'b0;
        state_r <= ST_IDLE;
        cnt_r <= 8'h00;
        div_r <= 8'h00;
        cur_ch_r <= 3'h0;
        cur_src_r <= 1'b0;
        cur_q_r <= 6'h00;
        trig_seen_r <= 2'h0;
        rdata <= 8'h00;
        conv_channel <= 3'h0;
        conv_sample <= 1'b0;
        service_request_lines <= 2'h0;
    end else begin
        div_r <= tick ? (`CONV_CLK_DIV - 8'h01) : div_r - 8'h01;
        load_pend_r <= 1'b0;
        if (trig0_edge & qv_r[0]) begin
            trig_seen_r[0] <= 1'b1;
        end
        if (wr) begin
            if (addr < `A_SAMPLE_TIME) begin
                channel_control[addr[2:0]] <= wdata;
            end
            case (addr)
                `A_SAMPLE_TIME: input_class_sample_time <= wdata;
                `A_ARB_CTRL: arb_r <= wdata;
                `A_QUEUE_MODE: begin
                    qmode_r <= wdata;
                    if (wdata[1]) begin
                        qv_r <= 4'h0;
                    end
                    if (wdata[2] & qv_r[0]) begin
                        trig_seen_r[0] <= 1'b1;
                    end
                end
                `A_QUEUE_IN: begin
                    if (!full) begin
                        if (!qv_r[0]) begin
                            q_r[0] <= wdata[5:0];
                            qv_r[0] <= 1'b1;
                        end
                        for (i = 1; i < 4; i = i + 1) begin
                            if (!qv_r[i] && qv_r[i-1]) begin
                                q_r[i] <= wdata[5:0];
                                qv_r[i] <= 1'b1;
                            end
                        end
                    end
                end
                `A_PAR_REQ: par_req_r <= wdata[3:0];
                `A_PAR_PEND: begin
                    par_req_r <= wdata[3:0];
                    load_pend_r <= 1'b1;
                end
                `A_PAR_MODE: par_mode_r <= {wdata[7:2], 1'b0, wdata[0]};
                `A_TRIG_CTRL: trig_r <= wdata;
                `A_LOWER_BOUND: lower_limit_bound <= {wdata, 2'b00};
                `A_UPPER_BOUND: upper_limit_bound <= {wdata, 2'b11};
                `A_SR_ROUTE_EV: route_ev_r <= wdata;
                `A_SR_ROUTE_CH: route_ch_r <= wdata;
                `A_EVENT_FLAGS: ev_flag_r <= ev_flag_r & ~wdata;
                `A_STATUS: ch_flag_r <= ch_flag_r & ~wdata;
                default: ;
            endcase
        end
        if (load_pend_r | (wr & (addr == `A_PAR_MODE) & wdata[1]) | (trig1_edge & par_mode_r[2])) begin
            par_pend_r <= par_req_r;
        end
        if (rd) begin
            rdata <= 8'h00;
            if (addr < `A_SAMPLE_TIME) begin
                rdata <= channel_control[addr[2:0]];
            end
            case (addr)
                `A_SAMPLE_TIME: rdata <= input_class_sample_time;
                `A_ARB_CTRL: rdata <= arb_r;
                `A_QUEUE_MODE: rdata <= {qv_r, qmode_r[3:0]};
                `A_PAR_REQ: rdata <= {4'h0, par_req_r};
                `A_PAR_PEND: rdata <= {4'h0, par_pend_r};
                `A_PAR_MODE: rdata <= par_mode_r;
                `A_TRIG_CTRL: rdata <= trig_r;
                `A_LOWER_BOUND: rdata <= lower_limit_bound[9:2];
                `A_UPPER_BOUND: rdata <= upper_limit_bound[9:2];
                `A_SR_ROUTE_EV: rdata <= route_ev_r;
                `A_SR_ROUTE_CH: rdata <= route_ch_r;
                `A_STATUS: rdata <= {busy, conv_sample, 2'b00, res_valid_r};
                `A_EVENT_FLAGS: rdata <= ev_flag_r;
                default: ;
            endcase
            if (addr >= `A_RESULT0 && addr < `A_RESULT_ACC0) begin
                rdata <= res_r[addr[1:0]][9:2];
                res_valid_r[addr[1:0]] <= 1'b0;
            end else if (addr >= `A_RESULT_ACC0) begin
                rdata <= res_r[addr[1:0]][10:3];
                res_valid_r[addr[1:0]] <= 1'b0;
            end
        end
        // Grants land on a converter clock edge so the start phase lasts exactly one period.
        if ((seq_win | par_win) & (~busy | cancel_ok) & tick) begin
            if (cancel_ok & cur_src_r) begin
                par_pend_r[cur_ch_r[1:0]] <= 1'b1;
            end
            if (cancel_ok & ~cur_src_r & ~full) begin
                q_r[0] <= cur_q_r;
                qv_r[0] <= 1'b1;
                trig_seen_r[0] <= 1'b1;
                for (i = 1; i < 4; i = i + 1) begin
                    q_r[i] <= q_r[i-1];
                    qv_r[i] <= qv_r[i-1];
                end
            end
            state_r <= ST_START;
            cnt_r <= `START_DELAY;
            cur_src_r <= par_win;
            conv_sample <= 1'b1;
            if (seq_win) begin
                cur_ch_r <= q_head[2:0];
                conv_channel <= q_head[2:0];
                cur_q_r <= q_head;
                trig_seen_r[0] <= 1'b0;
                if (!(cancel_ok & ~cur_src_r)) begin
                    for (i = 0; i < 3; i = i + 1) begin
                        q_r[i] <= q_r[i+1];
                        qv_r[i] <= qv_r[i+1];
                    end
                    qv_r[3] <= 1'b0;
                end
            end else begin
                cur_ch_r <= par_ch;
                conv_channel <= par_ch;
                par_pend_r[par_bit] <= 1'b0;
            end
        end else if (tick) begin
            case (state_r)
                ST_START: begin
                    state_r <= ST_SAMPLE;
                    cnt_r <= `SAMPLE_BASE + input_class_sample_time - 8'h01;
                end
                ST_SAMPLE: begin
                    if (cnt_r == 8'h00) begin
                        state_r <= ST_CONV;
                        conv_sample <= 1'b0;
                        cnt_r <= `CONV_PERIODS;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ST_CONV: begin
                    if (done) begin
                        state_r <= ST_IDLE;
                        res_valid_r[tgt] <= 1'b1;
                        if (acc_mode & res_cnt_r[tgt]) begin
                            res_r[tgt] <= acc[10:0];
                            res_cnt_r[tgt] <= 1'b0;
                        end else begin
                            res_r[tgt] <= {1'b0, conv_data};
                            res_cnt_r[tgt] <= acc_mode;
                        end
                        if (~(acc_mode & ~res_cnt_r[tgt])) begin
                            ev_flag_r[4 + tgt] <= 1'b1;
                        end
                        if (lim_hit) begin
                            ch_flag_r[cur_ch_r] <= 1'b1;
                        end
                        if (cur_src_r ? par_mode_r[3] : cur_q_r[5]) begin
                            ev_flag_r[cur_src_r] <= 1'b1;
                        end
                        if (~cur_src_r & cur_q_r[4] & ~full) begin
                            q_r[0] <= cur_q_r;
                            qv_r[0] <= 1'b1;
                            for (i = 1; i < 4; i = i + 1) begin
                                q_r[i] <= q_r[i-1];
                                qv_r[i] <= qv_r[i-1];
                            end
                        end
                        if (cur_src_r & par_mode_r[4] & ~(|par_pend_r)) begin
                            par_pend_r <= par_req_r;
                        end
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
        service_request_lines[0] <= |(ev_flag_r & ~route_ev_r) | |(ch_flag_r & ~route_ch_r);
        service_request_lines[1] <= |(ev_flag_r & route_ev_r) | |(ch_flag_r & route_ch_r);
    end
end

endmodule // adc_request_result_control

// ===== core/adc_ctrl_defines.vh
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
// Register indices on the plain register port.
`define A_CHAN_CTRL0 5'h00
`define A_SAMPLE_TIME 5'h08
`define A_ARB_CTRL 5'h09
`define A_QUEUE_IN 5'h0A
`define A_QUEUE_MODE 5'h0B
`define A_PAR_REQ 5'h0C
`define A_PAR_PEND 5'h0D
`define A_PAR_MODE 5'h0E
`define A_TRIG_CTRL 5'h0F
`define A_LOWER_BOUND 5'h10
`define A_UPPER_BOUND 5'h11
`define A_SR_ROUTE_EV 5'h12
`define A_SR_ROUTE_CH 5'h13
`define A_STATUS 5'h14
`define A_EVENT_FLAGS 5'h15
`define A_RESULT0 5'h18
`define A_RESULT_ACC0 5'h1C
// Channel control fields.
`define F_TARGET_LSB 0
`define F_LIMIT_LSB 2
// Reset values.
`define RST_CHAN_CTRL 8'h00
`define RST_SAMPLE_TIME 8'h00
`define RST_ARB_CTRL 8'h03
// Timing, in converter clock periods; CONV_CLK_DIV in mclk cycles, QUEUE_DEPTH in entries.
`define SAMPLE_BASE 8'h02
`define START_DELAY 8'h01
`define CONV_PERIODS 8'h0B
`define CONV_CLK_DIV 8'h04
`define QUEUE_DEPTH 4
`endif

// ===== testbench/adc_ctrl_properties.sv
`timescale 1ns/1ps
module adc_ctrl_properties (
    input wire mclk,
    input wire rst_b,
    input wire [4:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire [7:0] trigger_lines,
    input wire [9:0] conv_data,
    input wire [2:0] conv_channel,
    input wire conv_sample,
    input wire [1:0] service_request_lines
);
    reg [7:0] chan_r [0:7];
    reg [7:0] stime_r;
    reg [10:0] hi_cnt_r;
    wire [10:0] nom = ({3'h0, stime_r} + 11'h003) * 11'h004;
    integer n;
    // Shadows of written settings and the length of the current high phase of conv_sample.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (n = 0; n < 8; n = n + 1) chan_r[n] <= 8'h00;
            stime_r <= 8'h00;
            hi_cnt_r <= 11'h000;
        end else begin
            if (wr && addr < 5'h08) chan_r[addr[2:0]] <= wdata;
            if (wr && addr == 5'h08) stime_r <= wdata;
            hi_cnt_r <= conv_sample ? hi_cnt_r + 11'h001 : 11'h000;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chan_readback_a:
        assert property (rd && addr < 5'h08 |=> rdata == chan_r[$past(addr)]) else $error("channel readback wrong");
    stime_readback_a:
        assert property (rd && addr == 5'h08 |=> rdata == stime_r) else $error("sample time readback wrong");
    unmapped_read_a:
        assert property (rd && (addr == 5'h16 || addr == 5'h17) |=> rdata == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a:
        assert property (!rd |=> $stable(rdata)) else $error("read data moved without a read");
    sample_min_a:
        assert property ($rose(conv_sample) |-> conv_sample [*8]) else $error("sample phase too short");
    sample_len_a:
        assert property ($fell(conv_sample) |-> hi_cnt_r == nom)
            else $error("sample phase length wrong");
    sample_chan_a:
        assert property (conv_sample && $past(conv_sample) |-> $stable(conv_channel)) else $error("channel moved in sample");
    conv_gap_a:
        assert property ($fell(conv_sample) |-> !conv_sample [*8]) else $error("next sample during conversion");
endmodule // adc_ctrl_properties
bind adc_request_result_control adc_ctrl_properties u_props (.mclk(mclk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trigger_lines(trigger_lines), .conv_data(conv_data),
    .conv_channel(conv_channel), .conv_sample(conv_sample), .service_request_lines(service_request_lines));

// ===== testbench/trig_model.sv
`timescale 1ns/1ps
module trig_model (
    input wire mclk,
    input wire rst_b,
    input wire fire,
    input wire [2:0] line,
    output reg [7:0] trigger_lines
);
    // The timer side pulses exactly one of its eight event lines for one cycle.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) trigger_lines <= 8'h00;
        else trigger_lines <= fire ? (8'h01 << line) : 8'h00;
    end
endmodule // trig_model

// ===== testbench/adc_request_result_control_bench.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module adc_request_result_control_bench;
    reg mclk, rst_b, wr, rd, fire, ok;
    reg [4:0] addr;
    reg [7:0] wdata, v, m;
    reg [2:0] line, ch, c;
    reg [9:0] conv_data, d, e;
    reg [10:0] s;
    wire [7:0] rdata, trigger_lines;
    wire [2:0] conv_channel;
    wire conv_sample;
    wire [1:0] service_request_lines;
    int n_errors = 0, compares = 0, i, k;
    adc_request_result_control u_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trigger_lines(trigger_lines), .conv_data(conv_data), .conv_channel(conv_channel),
        .conv_sample(conv_sample), .service_request_lines(service_request_lines));
    trig_model u_trig (.mclk(mclk), .rst_b(rst_b), .fire(fire), .line(line), .trigger_lines(trigger_lines));
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    function [7:0] acc_view(input [9:0] x);
        acc_view = {1'b0, x[9:3]};
    endfunction
    task wr_reg(input [4:0] a, input [7:0] x);
        @(posedge mclk);
        addr <= a; wdata <= x; wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [4:0] a, output [7:0] x);
        @(posedge mclk);
        addr <= a; rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    task pulse(input [2:0] l);
        @(posedge mclk);
        fire <= 1'b1; line <= l;
        @(posedge mclk);
        fire <= 1'b0;
    endtask
    // Waits for a sample phase to begin, notes its channel, then waits for it to end.
    task conv(input int lim, output [2:0] cc, output s);
        int j;
        s = 1'b0;
        for (j = 0; j < lim && !s; j++) begin
            @(posedge mclk);
            #1 s = (conv_sample === 1'b1);
        end
        cc = conv_channel;
        for (j = 0; j < 1200 && s && conv_sample !== 1'b0; j++) @(posedge mclk);
    endtask
    task final_report;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        final_report;
    end
    initial begin
        rst_b = 0; wr = 0; rd = 0; fire = 0; line = 0; addr = 0; wdata = 0; conv_data = 0;
        void'($urandom(32'hfc15402d));
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd_reg(i[4:0], v);
            `CHK("chan_rst", `RST_CHAN_CTRL, v)
        end
        rd_reg(`A_SAMPLE_TIME, v);
        `CHK("stime_rst", `RST_SAMPLE_TIME, v)
        rd_reg(`A_ARB_CTRL, v);
        `CHK("arb_rst", `RST_ARB_CTRL, v)
        rd_reg(5'h16, v);
        `CHK("unmapped", 8'h00, v)
        for (i = 0; i < 8; i++) begin
            m = $urandom;
            wr_reg(i[4:0], m);
            rd_reg(i[4:0], v);
            `CHK("chan_rw", m, v)
        end
        wr_reg(`A_SAMPLE_TIME, $urandom % 4);
        wr_reg(`A_QUEUE_MODE, 8'h01);
        for (i = 0; i < 4; i++) begin
            d = $urandom;
            ch = $urandom;
            wr_reg(`A_CHAN_CTRL0 + ch, i[7:0]);
            wr_reg(`A_QUEUE_IN, {5'h00, ch});
            conv_data <= d;
            conv(300, c, ok);
            `CHK("seq_ch", ch, c)
            repeat (60) @(posedge mclk);
            rd_reg(`A_STATUS, v);
            `CHK("valid_set", 1'b1, v[i])
            rd_reg(`A_RESULT_ACC0 + i[4:0], v);
            `CHK("acc_view", acc_view(d), v)
            rd_reg(`A_RESULT0 + i[4:0], v);
            `CHK("target", d[9:2], v)
            rd_reg(`A_STATUS, v);
            `CHK("valid_clr", 1'b0, v[i])
        end
        wr_reg(`A_PAR_MODE, 8'h01);
        for (i = 0; i < 2; i++) begin
            m = i ? 8'h05 : 8'h0F;
            if (i) begin
                wr_reg(`A_PAR_REQ, m);
                wr_reg(`A_PAR_MODE, 8'h03);
            end else wr_reg(`A_PAR_PEND, m);
            for (k = 3; k >= 0; k--) if (m[k]) begin
                conv(300, c, ok);
                `CHK("par_order", k[2:0] + 3'h4, c)
            end
            conv(300, c, ok);
            `CHK("par_done", 1'b0, ok)
        end
        wr_reg(`A_QUEUE_MODE, 8'h00);
        for (i = 1; i < 6; i++) wr_reg(`A_QUEUE_IN, i[7:0]);
        wr_reg(`A_QUEUE_MODE, 8'h01);
        for (i = 1; i < 5; i++) begin
            conv(300, c, ok);
            `CHK("queue_ch", i[2:0], c)
        end
        conv(300, c, ok);
        `CHK("queue_full", 1'b0, ok)
        repeat (60) @(posedge mclk);
        for (i = 0; i < 4; i++) rd_reg(`A_RESULT0 + i[4:0], v);
        wr_reg(`A_CHAN_CTRL0, 8'h00);
        wr_reg(`A_ARB_CTRL, 8'h43);
        for (i = 0; i < 2; i++) begin
            wr_reg(`A_QUEUE_IN, 8'h00);
            conv(300, c, ok);
            `CHK("wfr_run", ~i[0], ok)
        end
        rd_reg(`A_RESULT0, v);
        conv(300, c, ok);
        `CHK("wfr_free", 1'b1, ok)
        wr_reg(`A_ARB_CTRL, 8'h03);
        for (i = 0; i < 2; i++) begin
            repeat (60) @(posedge mclk);
            wr_reg(`A_EVENT_FLAGS, 8'hFF);
            wr_reg(`A_STATUS, 8'hFF);
            // First pass: only the sequential source event may reach line 0, all else line 1; second pass: everything goes to line 1.
            wr_reg(`A_SR_ROUTE_EV, i ? 8'hFF : 8'hFE);
            wr_reg(`A_SR_ROUTE_CH, 8'hFF);
            wr_reg(`A_QUEUE_IN, 8'h21);
            conv(300, c, ok);
            repeat (60) @(posedge mclk);
            `CHK("srq_line0", ~i[0], service_request_lines[0])
            `CHK("srq_line1", 1'b1, service_request_lines[1])
            rd_reg(`A_EVENT_FLAGS, v);
            `CHK("src_event", 1'b1, v[0])
        end
        for (i = 0; i < 8; i++) begin
            wr_reg(`A_TRIG_CTRL, {4'h0, 1'($urandom % 2), i[2:0]});
            wr_reg(`A_QUEUE_IN, 8'h0B);
            pulse(i[2:0] + 3'h1);
            conv(40, c, ok);
            `CHK("trig_other", 1'b0, ok)
            pulse(i[2:0]);
            conv(40, c, ok);
            `CHK("trig_sel", 1'b1, ok)
        end
        // Both sources pending at once: equal priority, then the parallel source raised.
        for (i = 0; i < 2; i++) begin
            wr_reg(`A_ARB_CTRL, 8'h00);
            wr_reg(`A_QUEUE_IN, 8'h02);
            wr_reg(`A_PAR_PEND, 8'h01);
            wr_reg(`A_ARB_CTRL, i ? 8'h0B : 8'h03);
            conv(300, c, ok);
            `CHK("arb_first", i ? 3'h4 : 3'h2, c)
            conv(300, c, ok);
            `CHK("arb_second", i ? 3'h2 : 3'h4, c)
        end
        // Two results into register 0 with accumulation on.
        repeat (60) @(posedge mclk);
        wr_reg(`A_ARB_CTRL, 8'h83);
        wr_reg(`A_EVENT_FLAGS, 8'hFF);
        d = $urandom;
        e = $urandom;
        for (i = 0; i < 2; i++) begin
            wr_reg(`A_QUEUE_IN, 8'h00);
            conv_data <= i ? e : d;
            conv(300, c, ok);
            repeat (60) @(posedge mclk);
            rd_reg(`A_EVENT_FLAGS, v);
            `CHK("res_event", i[0], v[4])
        end
        s = {1'b0, d} + {1'b0, e};
        rd_reg(`A_RESULT_ACC0, v);
        `CHK("acc_sum", s[10:3], v)
        // Channel 0 flags only inside the bounds; channel flags go to line 1 alone.
        wr_reg(`A_CHAN_CTRL0, 8'h04);
        wr_reg(`A_LOWER_BOUND, 8'h40);
        wr_reg(`A_UPPER_BOUND, 8'h80);
        wr_reg(`A_SR_ROUTE_CH, 8'hFF);
        wr_reg(`A_SR_ROUTE_EV, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr_reg(`A_STATUS, 8'hFF);
            wr_reg(`A_QUEUE_IN, 8'h00);
            conv_data <= i ? 10'h3F0 : 10'h180;
            conv(300, c, ok);
            repeat (60) @(posedge mclk);
            `CHK("limit_irq", ~i[0], service_request_lines[1])
        end
        final_report;
    end
endmodule // adc_request_result_control_bench
